/* prot_stage_common.sv */
// Common protection stage control: setting groups, stage status, timers, forcing
`timescale 1ns/100ps
`default_nettype none

// Operation
// - At most about thirty stages enabled
// - No control input active: default group
// - Active control input selects its group
// - Each group has own input selector
// - Priority picks lowest or highest active group
// - Virtual inputs can also select groups
// - Stage status: idle, blocked, start, trip
// - Force flag allows forcing start/trip 0.5s
// - Force flag clears five minutes after keys
// - Force flag also permits relay, mA forcing
// - Each stage gives start and trip
// - Start on fault, trip after delay
// - Stages blockable by internal, external sources
// - Some stages have built-in blocking
// - Blocked stage does not pick up
// - Blocking freezes running operation delay
// - Blocking after trip has no effect
// - Cleared fault abandons timing within 50ms
// - Reset delay then release unless latched
// - Reset delay at most 95 ms
// - Hysteresis on pick-up comparison
module prot_stage_common
  import prot_stage_pkg::*;
#(
  parameter int NUM_STAGES   = 4,
  parameter int TICK_CYC     = TICK_CYCLES,
  parameter int FORCE_TO_MS  = FORCE_TIMEOUT_MS
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // Wishbone slave
  input  wire logic                        wbCyc,
  input  wire logic                        wbStb,
  input  wire logic                        wbWe,
  input  wire logic [11:0]                 wbAdr,
  input  wire logic [3:0]                  wbSel,
  input  wire logic [31:0]                 wbDatI,
  output var  logic [31:0]                 wbDatO,
  output var  logic                        wbAck,
  // Pins: digital inputs, function keys, front panel keys
  input  wire logic [NUM_DI-1:0]           dIn,
  input  wire logic [NUM_FKEY-1:0]         fKey,
  input  wire logic                        panelKey,
  // Stage inputs from measurement and blocking matrix
  input  wire stage_in_t [MAX_STAGES-1:0]  stageIn,
  // Stage outputs to output matrix
  output var  logic [MAX_STAGES-1:0]       startOut,
  output var  logic [MAX_STAGES-1:0]       tripOut,
  output var  logic [1:0]                  activeGroup,
  output var  logic                        forcePermit
);

  // Bad sizes stop elaboration rather than misbehave at run time
  if (NUM_STAGES < 1 || NUM_STAGES > MAX_STAGES) begin : g_bad_stages
    $error("NUM_STAGES out of range");
  end
  if (TICK_CYC < 1 || TICK_CYC > 16777215) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end
  if (FORCE_TO_MS < 1 || FORCE_TO_MS > 524287) begin : g_bad_force
    $error("FORCE_TO_MS out of range");
  end

  state_t s;
  state_t next_s;

  function automatic logic srcBit(input logic [5:0] sel, input logic [NUM_DI-1:0] di,
                                  input logic [NUM_VI-1:0] vi, input logic [NUM_FKEY-1:0] fk);
    logic r;
    r = 1'b0;
    if (sel >= SRC_DI && sel < SRC_VI) r = di[4'(sel - SRC_DI)];
    else if (sel >= SRC_VI && sel < SRC_FKEY) r = vi[4'(sel - SRC_VI)];
    else if (sel >= SRC_FKEY && sel < SRC_FKEY + 6'(NUM_FKEY)) r = fk[2'(sel - SRC_FKEY)];
    return r;
  endfunction

  logic [NUM_GROUPS-1:0] grpReq;
  logic [MAX_STAGES-1:0] enEff;
  stage_st_t [MAX_STAGES-1:0] stVis;
  logic [31:0] rd;
  logic [31:0] wv;
  logic [31:0] mask;
  logic        hit;
  logic        wr;
  logic [5:0]  enCount;
  logic [2:0]  si;
  logic [15:0] pk;
  logic        blk;
  logic        f;
  logic        forcedHere;
  logic        stOn;
  logic        trOn;

  always_comb begin
    next_s = s;
    grpReq = '0;
    enEff = '0;
    stVis = s.st;
    rd = 32'h0;
    mask = 32'h0;
    wv = 32'h0;
    enCount = 6'h0;
    si = 3'h0;
    pk = 16'h0;
    blk = 1'b0;
    f = 1'b0;
    forcedHere = 1'b0;
    stOn = 1'b0;
    trOn = 1'b0;

    // Two-flop synchronisers for pins
    next_s.dInS1 = dIn;
    next_s.dInS2 = s.dInS1;
    next_s.fKeyS1 = fKey;
    next_s.fKeyS2 = s.fKeyS1;
    next_s.keyS1 = panelKey;
    next_s.keyS2 = s.keyS1;
    next_s.keyPrev = s.keyS2;

    // Millisecond tick drives all stage timers
    if (s.tickCnt == 24'(TICK_CYC - 1)) begin
      next_s.tickCnt = 24'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tickCnt = s.tickCnt + 24'h1;
      next_s.tick = 1'b0;
    end

    // Setting group selection
    for (int g = 0; g < NUM_GROUPS; g++) begin
      grpReq[g] = srcBit(s.groupSel[g], s.dInS2, s.virtIn, s.fKeyS2);
    end
    next_s.activeGroup = s.defGroup;
    if (s.prioDesc) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (grpReq[g]) next_s.activeGroup = 2'(g);
      end
    end else begin
      for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
        if (grpReq[g]) next_s.activeGroup = 2'(g);
      end
    end

    // Enable cap counts lower-numbered stages first
    for (int i = 0; i < MAX_STAGES; i++) begin
      if (s.stageEn[i] && i < NUM_STAGES && enCount < 6'(MAX_ENABLED)) begin
        enEff[i] = 1'b1;
        enCount = enCount + 6'h1;
      end
    end

    // Visible status includes test forcing
    if (s.forceCnt != 10'h0 && 32'(s.forceStage) < NUM_STAGES) begin
      stVis[s.forceStage] = s.forceTrip ? ST_TRIP : ST_START;
    end

    // Wishbone register read
    hit = wbCyc && wbStb && !s.wbAck;
    wr = hit && wbWe;
    for (int b = 0; b < 4; b++) begin
      mask[b*8 +: 8] = {8{wbSel[b]}};
    end
    if (wbAdr == REG_CTRL) begin
      rd[CTRL_DEFGRP_LSB +: 2] = s.defGroup;
      rd[CTRL_PRIO_BIT] = s.prioDesc;
      rd[CTRL_FORCE_BIT] = s.forceFlag;
    end else if (wbAdr == REG_GROUP_SEL) begin
      for (int g = 0; g < NUM_GROUPS; g++) rd[g*SEL_FIELD_STRIDE +: 6] = s.groupSel[g];
    end else if (wbAdr == REG_VIRT_IN) begin
      rd[NUM_VI-1:0] = s.virtIn;
    end else if (wbAdr == REG_STATUS) begin
      rd[1:0] = s.activeGroup;
      rd[CTRL_FORCE_BIT] = s.forceFlag;
      for (int i = 0; i < MAX_STAGES; i++) rd[STATUS_STAGE_LSB + 2*i +: 2] = stVis[i];
    end else if (wbAdr == REG_STAGE_EN) begin
      rd[MAX_STAGES-1:0] = s.stageEn;
    end else if (wbAdr == REG_OUTPUTS) begin
      rd[MAX_STAGES-1:0] = s.startOut;
      rd[8 +: MAX_STAGES] = s.tripOut;
    end else if (wbAdr >= REG_CFG_BASE && wbAdr < REG_CFG_BASE + 12'h020 &&
                 wbAdr[1:0] == 2'h0) begin
      si = wbAdr[4:2];
      rd[15:0] = s.opDelay[si];
      rd[CFG_RST_LSB +: 7] = s.rstDelay[si];
      rd[CFG_UNDER_BIT] = s.under[si];
      rd[CFG_LATCH_BIT] = s.latchCfg[si];
    end else if (wbAdr >= REG_PICK_BASE && wbAdr < REG_PICK_BASE + 12'h080 &&
                 wbAdr[1:0] == 2'h0) begin
      rd[15:0] = s.pickup[wbAdr[6:2]];
    end
    wv = (rd & ~mask) | (wbDatI & mask);
    next_s.wbAck = hit;
    if (hit) next_s.wbDat = wbWe ? 32'h0 : rd;

    // Force flag idle timeout, restarted by any panel key press
    if (s.keyS2 && !s.keyPrev) begin
      next_s.forceIdle = 19'(FORCE_TO_MS);
    end else if (s.forceFlag && s.tick) begin
      if (s.forceIdle == 19'h0) next_s.forceFlag = 1'b0;
      else next_s.forceIdle = s.forceIdle - 19'h1;
    end
    if (s.forceCnt != 10'h0 && s.tick) next_s.forceCnt = s.forceCnt - 10'h1;

    // Register writes
    if (wr) begin
      if (wbAdr == REG_CTRL) begin
        next_s.defGroup = wv[CTRL_DEFGRP_LSB +: 2];
        next_s.prioDesc = wv[CTRL_PRIO_BIT];
        next_s.forceFlag = wv[CTRL_FORCE_BIT];
        if (wv[CTRL_FORCE_BIT] && !s.forceFlag) next_s.forceIdle = 19'(FORCE_TO_MS);
      end else if (wbAdr == REG_GROUP_SEL) begin
        for (int g = 0; g < NUM_GROUPS; g++) next_s.groupSel[g] = wv[g*SEL_FIELD_STRIDE +: 6];
      end else if (wbAdr == REG_VIRT_IN) begin
        next_s.virtIn = wv[NUM_VI-1:0];
      end else if (wbAdr == REG_STAGE_EN) begin
        next_s.stageEn = wv[MAX_STAGES-1:0];
      end else if (wbAdr == REG_FORCE_CMD && s.forceFlag && wbSel[0]) begin
        next_s.forceStage = wbDatI[2:0];
        next_s.forceTrip = wbDatI[FCMD_TRIP_BIT];
        next_s.forceCnt = 10'(FORCE_HOLD_MS);
      end else if (wbAdr == REG_LATCH_CLR && wbSel[0]) begin
        next_s.latStart = s.latStart & ~wbDatI[MAX_STAGES-1:0];
        next_s.latTrip = s.latTrip & ~wbDatI[MAX_STAGES-1:0];
      end else if (wbAdr >= REG_CFG_BASE && wbAdr < REG_CFG_BASE + 12'h020 &&
                   wbAdr[1:0] == 2'h0) begin
        next_s.opDelay[si] = wv[15:0];
        // Longer release delays are clamped rather than refused
        if (wv[CFG_RST_LSB +: 7] > 7'(RESET_DELAY_MAX_MS))
          next_s.rstDelay[si] = 7'(RESET_DELAY_MAX_MS);
        else
          next_s.rstDelay[si] = wv[CFG_RST_LSB +: 7];
        next_s.under[si] = wv[CFG_UNDER_BIT];
        next_s.latchCfg[si] = wv[CFG_LATCH_BIT];
      end else if (wbAdr >= REG_PICK_BASE && wbAdr < REG_PICK_BASE + 12'h080 &&
                   wbAdr[1:0] == 2'h0) begin
        next_s.pickup[wbAdr[6:2]] = wv[15:0];
      end
    end
    if (!next_s.forceFlag) next_s.forceCnt = 10'h0;

    // Per-stage state machine
    for (int i = 0; i < MAX_STAGES; i++) begin
      pk = s.pickup[{3'(i), s.activeGroup}];
      // Noise near the threshold must not chatter the fault flag
      if (s.under[i]) begin
        if (!s.fault[i]) f = stageIn[i].meas < pk;
        else f = !({1'b0, stageIn[i].meas} > {1'b0, pk} + {1'b0, HYST_WIDTH});
      end else begin
        if (!s.fault[i]) f = stageIn[i].meas > pk;
        else f = !({1'b0, stageIn[i].meas} + {1'b0, HYST_WIDTH} < {1'b0, pk});
      end
      blk = stageIn[i].blockExt || stageIn[i].blockBuiltin;
      if (!enEff[i]) begin
        next_s.st[i] = ST_IDLE;
        next_s.fault[i] = 1'b0;
        next_s.dlyCnt[i] = 16'h0;
        next_s.holdStart[i] = 1'b0;
        next_s.holdTrip[i] = 1'b0;
      end else begin
        next_s.fault[i] = f;
        if (s.holdStart[i] || s.holdTrip[i]) begin
          if (s.rstCnt[i] == 7'h0) begin
            next_s.holdStart[i] = 1'b0;
            next_s.holdTrip[i] = 1'b0;
          end else if (s.tick) begin
            next_s.rstCnt[i] = s.rstCnt[i] - 7'h1;
          end
        end
        case (s.st[i])
          ST_IDLE: begin
            if (f && blk) next_s.st[i] = ST_BLOCKED;
            else if (f) begin
              next_s.st[i] = ST_START;
              next_s.dlyCnt[i] = 16'h0;
            end
          end
          ST_BLOCKED: begin
            if (!f) begin
              next_s.st[i] = ST_IDLE;
              next_s.dlyCnt[i] = 16'h0;
            end else if (!blk) next_s.st[i] = ST_START;
          end
          ST_START: begin
            if (!f) begin
              // Abandon timing at once, well inside the retardation limit
              next_s.st[i] = ST_IDLE;
              next_s.dlyCnt[i] = 16'h0;
              next_s.holdStart[i] = s.rstDelay[i] != 7'h0;
              next_s.rstCnt[i] = s.rstDelay[i];
            end else if (blk) next_s.st[i] = ST_BLOCKED;
            else if (s.dlyCnt[i] >= s.opDelay[i]) next_s.st[i] = ST_TRIP;
            else if (s.tick) next_s.dlyCnt[i] = s.dlyCnt[i] + 16'h1;
          end
          ST_TRIP: begin
            // Blocking is not looked at here
            if (!f) begin
              next_s.st[i] = ST_IDLE;
              next_s.dlyCnt[i] = 16'h0;
              next_s.holdStart[i] = s.rstDelay[i] != 7'h0;
              next_s.holdTrip[i] = s.rstDelay[i] != 7'h0;
              next_s.rstCnt[i] = s.rstDelay[i];
            end
          end
          default: next_s.st[i] = ST_IDLE;
        endcase
      end
      forcedHere = s.forceCnt != 10'h0 && s.forceStage == 3'(i) && i < NUM_STAGES;
      stOn = s.st[i] == ST_START || s.st[i] == ST_TRIP || s.holdStart[i] || s.latStart[i];
      trOn = s.st[i] == ST_TRIP || s.holdTrip[i] || s.latTrip[i];
      // Latch set wins over a clear written in the same cycle
      if (s.latchCfg[i] && (s.st[i] == ST_START || s.st[i] == ST_TRIP))
        next_s.latStart[i] = 1'b1;
      if (s.latchCfg[i] && s.st[i] == ST_TRIP) next_s.latTrip[i] = 1'b1;
      next_s.startOut[i] = stOn || forcedHere;
      next_s.tripOut[i] = trOn || (forcedHere && s.forceTrip);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.defGroup <= RST_DEFGRP;
      s.opDelay <= {MAX_STAGES{RST_OP_DELAY}};
      s.rstDelay <= {MAX_STAGES{RST_RST_DLY}};
      s.pickup <= {(MAX_STAGES*4){RST_PICKUP}};
    end else begin
      s <= next_s;
    end
  end

  assign wbDatO = s.wbDat;
  assign wbAck = s.wbAck;
  assign startOut = s.startOut;
  assign tripOut = s.tripOut;
  assign activeGroup = s.activeGroup;
  assign forcePermit = s.forceFlag;

endmodule // prot_stage_common

`default_nettype wire

/* prot_stage_pkg.sv */
// Shared constants, register map and carrier types for the protection stage logic
package prot_stage_pkg;

  // Sizing
  localparam int MAX_STAGES   = 8;
  localparam int MAX_ENABLED  = 30;
  localparam int NUM_GROUPS   = 4;
  localparam int NUM_DI       = 16;
  localparam int NUM_VI       = 16;
  localparam int NUM_FKEY     = 4;

  // Timing: clock, millisecond tick and documented times
  localparam int CLK_PERIOD_NS       = 5;
  localparam int TICK_TIME_NS        = 1000000;
  localparam int TICK_CYCLES         = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FORCE_HOLD_MS       = 500;
  localparam int FORCE_TIMEOUT_MIN   = 5;
  localparam int FORCE_TIMEOUT_MS    = FORCE_TIMEOUT_MIN * 60 * 1000;
  localparam int RESET_DELAY_MAX_MS  = 95;
  localparam int RETARD_MAX_MS       = 50;
  localparam logic [15:0] HYST_WIDTH = 16'h0010;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_GROUP_SEL = 12'h004;
  localparam logic [11:0] REG_VIRT_IN   = 12'h008;
  localparam logic [11:0] REG_STATUS    = 12'h00c;
  localparam logic [11:0] REG_STAGE_EN  = 12'h010;
  localparam logic [11:0] REG_FORCE_CMD = 12'h014;
  localparam logic [11:0] REG_LATCH_CLR = 12'h018;
  localparam logic [11:0] REG_OUTPUTS   = 12'h01c;
  localparam logic [11:0] REG_CFG_BASE  = 12'h040;
  localparam logic [11:0] REG_PICK_BASE = 12'h080;

  // Field positions
  localparam int CTRL_DEFGRP_LSB   = 0;
  localparam int CTRL_PRIO_BIT     = 2;
  localparam int CTRL_FORCE_BIT    = 3;
  localparam int CFG_RST_LSB       = 16;
  localparam int CFG_UNDER_BIT     = 24;
  localparam int CFG_LATCH_BIT     = 25;
  localparam int FCMD_TRIP_BIT     = 3;
  localparam int STATUS_STAGE_LSB  = 8;
  localparam int SEL_FIELD_STRIDE  = 8;

  // Reset values
  localparam logic [1:0]  RST_DEFGRP   = 2'h0;
  localparam logic [15:0] RST_OP_DELAY = 16'h012c;
  localparam logic [6:0]  RST_RST_DLY  = 7'h28;
  localparam logic [15:0] RST_PICKUP   = 16'h1000;

  // Group selector source codes
  localparam logic [5:0] SRC_NONE = 6'h00;
  localparam logic [5:0] SRC_DI   = 6'h01;
  localparam logic [5:0] SRC_VI   = 6'h11;
  localparam logic [5:0] SRC_FKEY = 6'h21;

  typedef enum logic [1:0] {ST_IDLE, ST_BLOCKED, ST_START, ST_TRIP} stage_st_t;

  // Per-stage inputs from measurement and blocking matrix
  typedef struct packed {
    logic [15:0] meas;
    logic        blockExt;
    logic        blockBuiltin;
  } stage_in_t;

  typedef struct packed {
    logic [NUM_DI-1:0]                 dInS1;
    logic [NUM_DI-1:0]                 dInS2;
    logic [NUM_FKEY-1:0]               fKeyS1;
    logic [NUM_FKEY-1:0]               fKeyS2;
    logic                              keyS1;
    logic                              keyS2;
    logic                              keyPrev;
    logic [1:0]                        defGroup;
    logic                              prioDesc;
    logic                              forceFlag;
    logic [NUM_GROUPS-1:0][5:0]        groupSel;
    logic [NUM_VI-1:0]                 virtIn;
    logic [MAX_STAGES-1:0]             stageEn;
    logic [MAX_STAGES-1:0][15:0]       opDelay;
    logic [MAX_STAGES-1:0][6:0]        rstDelay;
    logic [MAX_STAGES-1:0]             under;
    logic [MAX_STAGES-1:0]             latchCfg;
    logic [MAX_STAGES*4-1:0][15:0]     pickup;
    logic [1:0]                        activeGroup;
    logic [23:0]                       tickCnt;
    logic                              tick;
    logic [18:0]                       forceIdle;
    logic [2:0]                        forceStage;
    logic                              forceTrip;
    logic [9:0]                        forceCnt;
    stage_st_t [MAX_STAGES-1:0]        st;
    logic [MAX_STAGES-1:0]             fault;
    logic [MAX_STAGES-1:0][15:0]       dlyCnt;
    logic [MAX_STAGES-1:0][6:0]        rstCnt;
    logic [MAX_STAGES-1:0]             holdStart;
    logic [MAX_STAGES-1:0]             holdTrip;
    logic [MAX_STAGES-1:0]             latStart;
    logic [MAX_STAGES-1:0]             latTrip;
    logic [MAX_STAGES-1:0]             startOut;
    logic [MAX_STAGES-1:0]             tripOut;
    logic                              wbAck;
    logic [31:0]                       wbDat;
  } state_t;

endpackage

/* prot_stage_common_props.sv */
// Port-level timing checker for the protection stage block
`timescale 1ns/100ps
`default_nettype none
module prot_stage_common_props
  import prot_stage_pkg::*;
#(
  parameter int TICK_CYC = 10
) (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       arst_n,
  // Wishbone
  input wire logic                       wbCyc,
  input wire logic                       wbStb,
  input wire logic                       wbWe,
  input wire logic [11:0]                wbAdr,
  input wire logic [31:0]                wbDatI,
  input wire logic                       wbAck,
  // Stage side
  input wire stage_in_t [MAX_STAGES-1:0] stageIn,
  input wire logic [MAX_STAGES-1:0]      startOut,
  input wire logic [MAX_STAGES-1:0]      tripOut,
  input wire logic                       forcePermit
);
  logic [15:0] dly;
  logic [6:0]  rst;
  logic        lat;
  int          faultCnt;
  int          clearCnt;
  logic        wrCfg;
  logic        blk0;
  assign wrCfg = wbCyc && wbStb && wbWe && wbAck && wbAdr == REG_CFG_BASE;
  assign blk0  = stageIn[0].blockExt || stageIn[0].blockBuiltin;
  // Mirror stage 0 timing set-up from bus writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dly      <= RST_OP_DELAY;
      rst      <= RST_RST_DLY;
      lat      <= 1'b0;
      faultCnt <= 0;
      clearCnt <= 0;
    end else begin
      if (wrCfg) begin
        dly <= wbDatI[15:0];
        rst <= (wbDatI[22:16] > 7'h5f) ? 7'h5f : wbDatI[22:16];
        lat <= wbDatI[CFG_LATCH_BIT];
      end
      faultCnt <= (stageIn[0].meas > RST_PICKUP) ? faultCnt + 1 : 0;
      clearCnt <= (stageIn[0].meas < RST_PICKUP - HYST_WIDTH) ? clearCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("bus request not answered next cycle");
  blocked_start_a: assert property ($rose(startOut[0]) && !forcePermit |-> !$past(blk0))
    else $error("start raised while blocked");
  trip_start_a: assert property ($rose(tripOut[0]) && !forcePermit |-> $past(startOut[0]))
    else $error("trip without preceding start");
  trip_hold_a: assert property (tripOut[0] && stageIn[0].meas > RST_PICKUP && !forcePermit
    |=> tripOut[0])
    else $error("trip dropped while fault present");
  op_delay_a: assert property ($rose(tripOut[0]) && !forcePermit
    |-> faultCnt >= (int'(dly) - 1) * TICK_CYC)
    else $error("trip before operation delay");
  rst_min_a: assert property ($fell(tripOut[0]) && !forcePermit
    |-> clearCnt >= (int'(rst) - 1) * TICK_CYC)
    else $error("trip released before reset delay");
  rst_max_a: assert property (clearCnt == (int'(rst) + 2) * TICK_CYC + 3 && !lat && !forcePermit
    |-> !startOut[0])
    else $error("start held past reset delay");
  force_sw_a: assert property ($rose(forcePermit) |-> wbAck || $past(wbAck))
    else $error("force flag set without a write");
  cover property ($rose(tripOut[0]));
  cover property (blk0 && stageIn[0].meas > RST_PICKUP);
  cover property ($fell(forcePermit));
endmodule // prot_stage_common_props
bind prot_stage_common prot_stage_common_props #(.TICK_CYC(TICK_CYC)) u_props (
  .mclk(mclk), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbDatI(wbDatI), .wbAck(wbAck), .stageIn(stageIn),
  .startOut(startOut), .tripOut(tripOut), .forcePermit(forcePermit));
`default_nettype wire

/* prot_stage_partner.sv */
// Far-side model: measurement levels, blocking sources and digital input pins
`timescale 1ns/100ps
`default_nettype none
module prot_stage_partner
  import prot_stage_pkg::*;
(
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  // Scenario commands
  input  wire logic [MAX_STAGES-1:0]      faultReq,
  input  wire logic [MAX_STAGES-1:0]      blockReq,
  input  wire logic                       lowVolt,
  input  wire logic                       nearRel,
  input  wire logic [NUM_DI-1:0]          dInReq,
  // Toward the block
  output var  stage_in_t [MAX_STAGES-1:0] stageIn,
  output var  logic [NUM_DI-1:0]          dIn
);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stageIn <= '0;
      dIn     <= '0;
    end else begin
      dIn <= dInReq;
      for (int i = 0; i < MAX_STAGES; i++) begin
        // Near level sits inside the dead band, so it must not release
        stageIn[i].meas <= faultReq[i] ? 16'h1200 : (nearRel ? 16'h0ff8 : 16'h0e00);
        stageIn[i].blockExt <= blockReq[i];
        // Under-voltage style inhibit reaches every stage
        stageIn[i].blockBuiltin <= lowVolt;
      end
    end
  end
endmodule // prot_stage_partner
`default_nettype wire

/* test_prot_stage_common.sv */
// Self-checking bench for the protection stage block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch %0t %s", $time, m); end end
module test_prot_stage_common
  import prot_stage_pkg::*;
;
  localparam int TK = 10;
  typedef struct packed {logic [15:0] vi; logic [3:0] ctrl; logic [1:0] grp;} row_t;
  row_t rows [7] = '{'{16'h0000, 4'h2, 2'h2}, '{16'h0001, 4'h0, 2'h0},
    '{16'h0008, 4'h1, 2'h3}, '{16'h0006, 4'h0, 2'h1}, '{16'h0006, 4'h4, 2'h2},
    '{16'h000f, 4'h4, 2'h3}, '{16'h000f, 4'h0, 2'h0}};
  logic mclk, arst_n, wbCyc, wbStb, wbWe, wbAck, panelKey, lowVolt, nearRel, forcePermit;
  logic [11:0] wbAdr;
  logic [3:0]  wbSel, fKey;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [15:0] dIn, dInReq;
  logic [7:0]  faultReq, blockReq, startOut, tripOut;
  logic [1:0]  activeGroup;
  stage_in_t [MAX_STAGES-1:0] stageIn;
  int error_cnt, checks_done;
  prot_stage_partner u_far (.mclk(mclk), .arst_n(arst_n), .faultReq(faultReq),
    .blockReq(blockReq), .lowVolt(lowVolt), .nearRel(nearRel), .dInReq(dInReq),
    .stageIn(stageIn), .dIn(dIn));
  prot_stage_common #(.NUM_STAGES(4), .TICK_CYC(TK), .FORCE_TO_MS(700)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .dIn(dIn), .fKey(fKey), .panelKey(panelKey), .stageIn(stageIn), .startOut(startOut),
    .tripOut(tripOut), .activeGroup(activeGroup), .forcePermit(forcePermit));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Request stands until ack is sampled high at a rising edge; data taken there
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatI <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) begin
      error_cnt++;
      $display("mismatch %0t bus timeout", $time);
      close_out();
    end else begin
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
    end
  endtask
  task automatic ms(input int n);
    repeat (n * TK) @(negedge mclk);
  endtask
  task automatic drive(input logic [7:0] f, input logic [7:0] b, input logic lv);
    @(posedge mclk);
    faultReq <= f;
    blockReq <= b;
    lowVolt  <= lv;
  endtask
  initial begin
    {arst_n, wbCyc, wbStb, wbWe, panelKey, lowVolt, nearRel} = '0;
    {wbAdr, wbDatI, dInReq, faultReq, blockReq, fKey} = '0;
    wbSel = 4'hf;
    error_cnt = 0;
    checks_done = 0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    ms(1);
    `CHK({startOut, tripOut, activeGroup}, 18'h0, "outputs after reset")
    wb(1'b0, REG_CFG_BASE, 32'h0);
    `CHK(rd, 32'h0028012c, "cfg reset value")
    wb(1'b0, 12'h3fc, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    wb(1'b1, REG_GROUP_SEL, 32'h14131211);
    foreach (rows[i]) begin
      wb(1'b1, REG_CTRL, {28'h0, rows[i].ctrl});
      wb(1'b1, REG_VIRT_IN, {16'h0, rows[i].vi});
      repeat (4) @(negedge mclk);
      `CHK(activeGroup, rows[i].grp, "active group")
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[1:0], rows[i].grp, "status group")
    end
    wb(1'b1, REG_VIRT_IN, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b1, REG_GROUP_SEL, 32'h14052111);
    @(posedge mclk);
    dInReq <= 16'h0010;
    repeat (6) @(negedge mclk);
    `CHK(activeGroup, 2'h2, "pin group select")
    @(posedge mclk);
    fKey <= 4'h1;
    repeat (10) @(negedge mclk);
    `CHK(activeGroup, 2'h1, "function key group")
    wb(1'b1, REG_STAGE_EN, 32'h1);
    wb(1'b1, REG_CFG_BASE, 32'h00030005);
    drive(8'h01, 8'h00, 1'b0);
    ms(1);
    `CHK(startOut[0], 1'b1, "start on fault")
    drive(8'h01, 8'h01, 1'b0);
    ms(10);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK({tripOut[0], rd[9:8]}, 3'h1, "blocked freezes delay")
    drive(8'h01, 8'h00, 1'b0);
    ms(2);
    `CHK(tripOut[0], 1'b0, "resumed count")
    ms(2);
    `CHK(tripOut[0], 1'b1, "trip from frozen count")
    drive(8'h01, 8'h01, 1'b0);
    ms(2);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK({tripOut[0], rd[9:8]}, 3'h7, "block after trip")
    @(posedge mclk);
    nearRel <= 1'b1;
    drive(8'h00, 8'h00, 1'b0);
    ms(5);
    `CHK(tripOut[0], 1'b1, "dead band holds fault")
    @(posedge mclk);
    nearRel <= 1'b0;
    ms(1);
    `CHK(tripOut[0], 1'b1, "reset delay hold")
    ms(4);
    `CHK({startOut[0], tripOut[0]}, 2'h0, "release after reset delay")
    drive(8'h01, 8'h00, 1'b1);
    ms(2);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK({startOut[0], rd[9:8]}, 3'h1, "builtin block")
    drive(8'h01, 8'h00, 1'b0);
    ms(2);
    drive(8'h00, 8'h00, 1'b0);
    ms(1);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[9:8], 2'h0, "cleared fault idle")
    ms(8);
    `CHK({startOut[0], tripOut[0]}, 2'h0, "no trip after clear")
    wb(1'b1, REG_CFG_BASE, 32'h02030005);
    drive(8'h01, 8'h00, 1'b0);
    ms(7);
    drive(8'h00, 8'h00, 1'b0);
    ms(10);
    `CHK(tripOut[0], 1'b1, "latched trip")
    wb(1'b1, REG_LATCH_CLR, 32'h1);
    ms(1);
    `CHK(tripOut[0], 1'b0, "latch cleared")
    wb(1'b1, REG_FORCE_CMD, 32'h8);
    ms(1);
    `CHK(tripOut[0], 1'b0, "force refused")
    wb(1'b1, REG_CTRL, 32'h8);
    `CHK(forcePermit, 1'b1, "force permit")
    wb(1'b1, REG_FORCE_CMD, 32'h8);
    ms(440);
    `CHK({startOut[0], tripOut[0]}, 2'h3, "forced trip")
    ms(100);
    `CHK(tripOut[0], 1'b0, "force ends")
    @(posedge mclk);
    panelKey <= 1'b1;
    ms(1);
    @(posedge mclk);
    panelKey <= 1'b0;
    ms(400);
    `CHK(forcePermit, 1'b1, "key restarts timeout")
    ms(400);
    `CHK(forcePermit, 1'b0, "force timeout")
    // Mid-run reset must restore the set-up values
    @(posedge mclk);
    arst_n <= 1'b0;
    @(negedge mclk);
    `CHK({startOut, tripOut, activeGroup}, 18'h0, "outputs in reset")
    @(posedge mclk);
    arst_n <= 1'b1;
    wb(1'b0, REG_CFG_BASE, 32'h0);
    `CHK(rd, 32'h0028012c, "cfg after reset")
    close_out();
  end
endmodule // test_prot_stage_common
`undef CHK
`default_nettype wire
